// ---- hw/lcrc_cell.sv ----
`timescale 1ns/100ps
`default_nettype none
// =====================================================================
// one logic cell: four-input lut and its storage element
// =====================================================================
module lcrc_cell (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  // configuration
  input  wire logic [15:0]          lut_mask,
  input  wire logic                 use_lut_chain,
  input  wire logic                 use_reg_chain,
  input  wire logic                 aload_mode,
  // data and chain inputs
  input  wire logic [3:0]           data_in,
  input  wire logic                 lut_chain_in,
  input  wire logic                 reg_chain_in,
  // register controls
  input  wire logic                 dev_clr,
  input  wire logic                 aclr,
  input  wire logic                 apre,
  input  wire logic                 ena,
  input  wire logic                 sclr,
  input  wire logic                 sload,
  // outputs
  output logic                      comb_out,
  output logic                      reg_out
);
  import lcrc_pkg::*;

  lcrc_cell_state_t st_q;  // stored state
  lcrc_cell_state_t st_d;  // next state
  logic [3:0]       lut_idx; // lut address after chain steering
  logic             d_in;    // synchronous data source
  logic             d4;      // cell_input_four

  assign d4 = data_in[LCRC_D4_IDX];

  // ===================================================================
  // lut and async overlay
  // ===================================================================
  // lut chain replaces the lowest data input with the cell above
  always_comb begin
    lut_idx    = data_in;
    lut_idx[0] = use_lut_chain ? lut_chain_in : data_in[0];
    comb_out   = lut_mask[lut_idx];
    d_in       = use_reg_chain ? reg_chain_in : comb_out;
  end

  // async controls act on the output at once, no clock needed
  always_comb begin
    if (dev_clr) begin
      reg_out = 1'b0;
    end else if (aclr) begin
      reg_out = 1'b0;
    end else if (apre) begin
      reg_out = aload_mode ? d4 : 1'b1;
    end else begin
      reg_out = st_q.q;
    end
  end

  // ===================================================================
  // next state
  // ===================================================================
  // stored bit follows the async overlay so it survives release
  always_comb begin
    st_d = st_q;
    if (dev_clr || aclr || apre) begin
      st_d.q = reg_out;
    end else if (ena) begin
      if (sclr) begin
        st_d.q = 1'b0;
      end else if (sload) begin
        st_d.q = d4;
      end else begin
        st_d.q = d_in;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ===================================================================
  // assertions
  // ===================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_clr_forces_zero: assert property (
    aclr |-> !reg_out) else $error("async clear did not force zero");
  a_preset_loads_one: assert property (
    !dev_clr && !aclr && apre && !aload_mode |-> reg_out)
    else $error("preset did not load one");
  a_clr_beats_pre: assert property (
    aclr && apre ##1 !aclr && !apre && !dev_clr && !ena |-> !reg_out)
    else $error("clear lost against preset");
  a_devrst_clears: assert property (
    dev_clr && ena && sload && d4 |=> !st_q.q || dev_clr)
    else $error("device reset did not override load");
  a_aload_d4_val: assert property (
    !dev_clr && !aclr && apre && aload_mode |-> reg_out == d4)
    else $error("async load not from input four");
  a_sclr_over_load: assert property (
    !dev_clr && !aclr && !apre && ena && sclr
    |=> dev_clr || aclr || apre || !reg_out)
    else $error("sync clear did not win");
  a_sload_takes_d4: assert property (
    !dev_clr && !aclr && !apre && ena && !sclr && sload
    |=> dev_clr || aclr || apre || reg_out == $past(d4))
    else $error("sync load wrong value");
  a_hold_no_ena: assert property (
    !dev_clr && !aclr && !apre && !ena
    |=> dev_clr || aclr || apre || $stable(reg_out))
    else $error("register changed without enable");

  c_clr_and_pre: cover property (aclr && apre);
  c_sync_load: cover property (ena && sload && !sclr);
  c_dev_clear: cover property (dev_clr && ena);

endmodule
`default_nettype wire

// ---- hw/lcrc_group.sv ----
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// =====================================================================
// =====================================================================
module lcrc_group #(
  parameter int unsigned NUM_CELLS  = lcrc_pkg::LCRC_NUM_CELLS,
  parameter bit          DEV_RST_EN = 1'b1  // honour device reset input
) (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_b,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [lcrc_pkg::LCRC_AW-1:0]  paddr,
  input  wire logic [lcrc_pkg::LCRC_DW-1:0]  pwdata,
  output logic      [lcrc_pkg::LCRC_DW-1:0]  prdata,
  output logic                               pready,
  output logic                               pslverr,
  // device-wide reset from the pin
  input  wire logic                          device_wide_reset_n,
  // group-wide register controls from fabric
  input  wire logic [lcrc_pkg::LCRC_NUM_CLR-1:0] grp_aclr,
  input  wire logic                          grp_apre,
  input  wire logic                          grp_ena,
  input  wire logic                          grp_sclr,
  input  wire logic                          grp_sload,
  // cell data inputs, four per cell
  input  wire logic [NUM_CELLS-1:0][3:0]     cell_data,
  // chain entry from the group above
  input  wire logic                          lut_chain_top,
  input  wire logic                          reg_chain_top,
  // cell outputs
  output logic      [NUM_CELLS-1:0]          cell_comb,
  output logic      [NUM_CELLS-1:0]          cell_reg
);
  import lcrc_pkg::*;

  // ===================================================================
  // state
  // ===================================================================
  typedef struct packed {
    logic [NUM_CELLS-1:0][15:0] lut_mask;   // per-cell lut contents
    logic [NUM_CELLS-1:0]       rchain_sel; // register chain in use
    logic [NUM_CELLS-1:0]       lchain_sel; // lut chain in use
    logic [NUM_CELLS-1:0]       clr_sel;    // which of two clears
    logic                       aload_mode; // preset acts as aload
    logic [LCRC_DW-1:0]         rdata;      // read data for access
    logic                       err;        // unmapped address seen
  } lcrc_grp_state_t;

  lcrc_grp_state_t st_q;                // registered state
  lcrc_grp_state_t st_d;                // next state
  logic            dev_clr;             // gated device reset
  logic [NUM_CELLS-1:0] lut_chain_in;   // chain into each cell
  logic [NUM_CELLS-1:0] reg_chain_in;   // register chain into cells
  logic [NUM_CELLS-1:0] cell_aclr;      // selected clear per cell
  logic            setup_ph;            // apb setup phase
  logic            wr_acc;              // apb write access phase

  // ===================================================================
  // address decode
  // ===================================================================
  // returns the lut mask slot, or NUM_CELLS when not a mask word
  function automatic int unsigned mask_slot(logic [LCRC_AW-1:0] a);
    int unsigned s;
    s = NUM_CELLS;
    for (int unsigned i = 0; i < NUM_CELLS; i++) begin
      if (a == LCRC_MASK_BASE + LCRC_AW'(4 * i)) begin
        s = i;
      end
    end
    return s;
  endfunction

  // ===================================================================
  // device reset and control distribution
  // ===================================================================
  // the build option removes the pin from every register
  assign dev_clr = DEV_RST_EN && !device_wide_reset_n;

  // each cell picks one of the two group clears
  always_comb begin
    for (int unsigned i = 0; i < NUM_CELLS; i++) begin
      cell_aclr[i] = grp_aclr[st_q.clr_sel[i]];
    end
  end

  // chains run from cell 0 down to the last cell of the group
  always_comb begin
    lut_chain_in[0] = lut_chain_top;
    reg_chain_in[0] = reg_chain_top;
    for (int unsigned i = 1; i < NUM_CELLS; i++) begin
      lut_chain_in[i] = cell_comb[i-1];
      reg_chain_in[i] = cell_reg[i-1];
    end
  end

  // ===================================================================
  // cells
  // ===================================================================
  // every cell sees the same group controls in every mode, except aclr, which each cell picks from grp_aclr by clr_sel
  for (genvar g = 0; g < NUM_CELLS; g++) begin : g_cell
    lcrc_cell u_cell (
      .sys_clk       (sys_clk),
      .rst_b         (rst_b),
      .lut_mask      (st_q.lut_mask[g]),
      .use_lut_chain (st_q.lchain_sel[g]),
      .use_reg_chain (st_q.rchain_sel[g]),
      .aload_mode    (st_q.aload_mode),
      .data_in       (cell_data[g]),
      .lut_chain_in  (lut_chain_in[g]),
      .reg_chain_in  (reg_chain_in[g]),
      .dev_clr       (dev_clr),
      .aclr          (cell_aclr[g]),
      .apre          (grp_apre),
      .ena           (grp_ena),
      .sclr          (grp_sclr),
      .sload         (grp_sload),
      .comb_out      (cell_comb[g]),
      .reg_out       (cell_reg[g])
    );
  end

  // ===================================================================
  // apb slave
  // ===================================================================
  assign setup_ph = psel && !penable;
  assign wr_acc   = psel && penable && pwrite;
  assign pready   = 1'b1;       // zero wait states
  assign prdata   = st_q.rdata; // captured in setup
  assign pslverr  = st_q.err;   // captured in setup

  // register writes in access, read data and error in setup
  always_comb begin
    int unsigned slot;
    slot = mask_slot(paddr);
    st_d = st_q;
    // write path
    if (wr_acc) begin
      if (slot < NUM_CELLS) begin
        st_d.lut_mask[slot] = pwdata[LCRC_LUT_BITS-1:0];
      end else if (paddr == LCRC_CFG_CHAIN) begin
        st_d.rchain_sel =
          pwdata[LCRC_RCHAIN_LSB +: NUM_CELLS];
        st_d.lchain_sel =
          pwdata[LCRC_LCHAIN_LSB +: NUM_CELLS];
      end else if (paddr == LCRC_CFG_CTRL) begin
        st_d.clr_sel    = pwdata[LCRC_CLRSEL_LSB +: NUM_CELLS];
        st_d.aload_mode = pwdata[LCRC_ALOAD_BIT];
      end
    end
    // read path, latched one cycle ahead of the access phase
    if (setup_ph) begin
      st_d.rdata = LCRC_ZERO32;
      st_d.err   = 1'b0;
      if (slot < NUM_CELLS) begin
        st_d.rdata[LCRC_LUT_BITS-1:0] = st_q.lut_mask[slot];
      end else if (paddr == LCRC_CFG_CHAIN) begin
        st_d.rdata[LCRC_RCHAIN_LSB +: NUM_CELLS] = st_q.rchain_sel;
        st_d.rdata[LCRC_LCHAIN_LSB +: NUM_CELLS] = st_q.lchain_sel;
      end else if (paddr == LCRC_CFG_CTRL) begin
        st_d.rdata[LCRC_CLRSEL_LSB +: NUM_CELLS] = st_q.clr_sel;
        st_d.rdata[LCRC_ALOAD_BIT] = st_q.aload_mode;
      end else if (paddr == LCRC_STATUS) begin
        st_d.rdata[LCRC_REGOUT_LSB +: NUM_CELLS] = cell_reg;
        st_d.rdata[LCRC_COMB_LSB +: NUM_CELLS]   = cell_comb;
      end else begin
        st_d.err = 1'b1; // unmapped address
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ===================================================================
  // assertions
  // ===================================================================
  a_devrst_all_zero: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    dev_clr |-> cell_reg == '0)
    else $error("device reset left a register set");
  // with the option off a low pin must leave a quiet register alone
  a_devrst_gated_off: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    !DEV_RST_EN && !device_wide_reset_n && !grp_apre && !cell_aclr[0]
    && !$past(grp_ena) |-> cell_reg[0] == $past(cell_reg[0]))
    else $error("device reset acted while disabled");
  a_reg_chain_shift: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    st_q.rchain_sel[1] && grp_ena && !grp_sclr && !grp_sload
    && !dev_clr && !grp_apre && !cell_aclr[1] && !wr_acc
    ##1 !dev_clr && !grp_apre && !cell_aclr[1]
    |-> cell_reg[1] == $past(cell_reg[0]))
    else $error("register chain did not shift");
  a_lut_chain_feed: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    st_q.lchain_sel[1] && cell_data[1] == '0
    |-> cell_comb[1] == st_q.lut_mask[1][cell_comb[0]])
    else $error("lut chain not cascaded");
  a_apb_unmapped: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    setup_ph && paddr == LCRC_STATUS |=> !pslverr)
    else $error("status read flagged as error");

  c_shift_run: cover property (@(posedge sys_clk)
    st_q.rchain_sel[1] && grp_ena ##1 grp_ena);
  c_status_read: cover property (@(posedge sys_clk)
    setup_ph && paddr == LCRC_STATUS);

endmodule
`default_nettype wire

// ---- hw/lcrc_pkg.sv ----
// =====================================================================
// shared constants for the logic cell group register control block
// =====================================================================
package lcrc_pkg;

  // group geometry
  localparam int unsigned LCRC_NUM_CELLS = 10;  // cells in one group
  localparam int unsigned LCRC_LUT_BITS  = 16;  // four-input lut mask
  localparam int unsigned LCRC_NUM_DATA  = 4;   // data inputs per cell
  localparam int unsigned LCRC_NUM_CLR   = 2;   // async clears per group
  localparam int unsigned LCRC_AW        = 12;  // apb address width
  localparam int unsigned LCRC_DW        = 32;  // apb data width

  // register byte offsets
  localparam logic [11:0] LCRC_MASK_BASE = 12'h000; // lut masks, 10 words
  localparam logic [11:0] LCRC_CFG_CHAIN = 12'h028; // chain selects
  localparam logic [11:0] LCRC_CFG_CTRL  = 12'h02C; // clear select, mode
  localparam logic [11:0] LCRC_STATUS    = 12'h030; // cell outputs

  // field positions
  localparam int unsigned LCRC_RCHAIN_LSB = 0;   // register chain select
  localparam int unsigned LCRC_LCHAIN_LSB = 16;  // lut chain select
  localparam int unsigned LCRC_CLRSEL_LSB = 0;   // clear line select
  localparam int unsigned LCRC_ALOAD_BIT  = 16;  // preset acts as aload
  localparam int unsigned LCRC_REGOUT_LSB = 0;   // status register outs
  localparam int unsigned LCRC_COMB_LSB   = 16;  // status comb outs
  localparam int unsigned LCRC_D4_IDX     = 3;   // cell_input_four index

  // reset values
  localparam logic [15:0] LCRC_MASK_RST = 16'h0000;
  localparam logic [9:0]  LCRC_SEL_RST  = 10'h000;
  localparam logic [31:0] LCRC_ZERO32   = 32'h0000_0000;

  // state of one cell: only the stored bit
  typedef struct packed {
    logic q;
  } lcrc_cell_state_t;

endpackage

// ---- sim/lcrc_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
// =====================================================================
// self-checking bench for the cell group register control block
// =====================================================================
`define CHK(g, e, m) chk((g), (e), (m))
module tb;
  import lcrc_pkg::*;
  logic                  sys_clk = 1'b0;  // 200 MHz
  logic                  rst_b   = 1'b0;  // async reset, active low
  logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [LCRC_AW-1:0]    paddr   = '0;
  logic [LCRC_DW-1:0]    pwdata  = '0;
  wire  logic [LCRC_DW-1:0] prdata;
  wire  logic            pready, pslverr;
  logic                  device_wide_reset_n = 1'b1;
  logic [1:0]            grp_aclr = '0;
  logic                  grp_apre = 1'b0, grp_ena = 1'b0;
  logic                  grp_sclr = 1'b0, grp_sload = 1'b0;
  logic [9:0][3:0]       cell_data = '0;
  logic                  lut_chain_top = 1'b0, reg_chain_top = 1'b0;
  wire  logic [9:0]      cell_comb, cell_reg;
  wire  logic [9:0]      nr_reg;  // register outs, reset pin ignored
  int                    error_cnt = 0;
  int                    comparisons = 0;
  logic [31:0]           rd;
  logic                  er;

  always #2.5 sys_clk = ~sys_clk;

  // main instance, device reset honoured
  lcrc_group #(.NUM_CELLS(10), .DEV_RST_EN(1'b1)) i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .device_wide_reset_n(device_wide_reset_n), .grp_aclr(grp_aclr),
    .grp_apre(grp_apre), .grp_ena(grp_ena), .grp_sclr(grp_sclr),
    .grp_sload(grp_sload), .cell_data(cell_data),
    .lut_chain_top(lut_chain_top), .reg_chain_top(reg_chain_top),
    .cell_comb(cell_comb), .cell_reg(cell_reg));

  // second build with the reset pin option off; shares the apb bus
  lcrc_group #(.NUM_CELLS(10), .DEV_RST_EN(1'b0)) i_dut_nr (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
    .pready(), .pslverr(),
    .device_wide_reset_n(device_wide_reset_n), .grp_aclr(grp_aclr),
    .grp_apre(grp_apre), .grp_ena(grp_ena), .grp_sclr(grp_sclr),
    .grp_sload(grp_sload), .cell_data(cell_data),
    .lut_chain_top(lut_chain_top), .reg_chain_top(reg_chain_top),
    .cell_comb(), .cell_reg(nr_reg));

  // one comparison, mismatches reported at once
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  // one apb transfer: setup, then access until pready seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) `CHK(1'b0, 1'b1, "apb answer never came");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // sync controls held for one capturing edge, then dropped
  task automatic sync_pulse(input logic e, input logic c, input logic l);
    @(posedge sys_clk);
    grp_ena <= e; grp_sclr <= c; grp_sload <= l;
    @(posedge sys_clk);
    grp_ena <= 1'b0; grp_sclr <= 1'b0; grp_sload <= 1'b0;
    #1;
  endtask

  // async controls applied just after an edge, looked at 1 ns later
  task automatic async_set(input logic [1:0] c, input logic p);
    @(posedge sys_clk);
    grp_aclr <= c; grp_apre <= p;
    #1;
  endtask

  // register reset values, read back, unmapped place
  task automatic t_regs();
    apb(1'b0, LCRC_CFG_CHAIN, '0); `CHK(rd, 32'h0, "chain cfg reset");
    apb(1'b0, LCRC_CFG_CTRL, '0);  `CHK(rd, 32'h0, "ctrl cfg reset");
    apb(1'b1, 12'h010, 32'h0000_1234);
    apb(1'b0, 12'h010, '0);        `CHK(rd, 32'h1234, "mask readback");
    apb(1'b0, 12'h040, '0);        `CHK(er, 1'b1, "unmapped error");
    `CHK(rd, 32'h0, "unmapped data");
  endtask

  // sync clear beats sync load, nothing without enable
  task automatic t_sync();
    cell_data <= '1;
    sync_pulse(1'b1, 1'b0, 1'b1); `CHK(cell_reg, 10'h3FF, "sload");
    sync_pulse(1'b1, 1'b1, 1'b1); `CHK(cell_reg, 10'h000, "sclr");
    sync_pulse(1'b0, 1'b0, 1'b1); `CHK(cell_reg, 10'h000, "no ena");
    sync_pulse(1'b1, 1'b0, 1'b1); `CHK(cell_reg, 10'h3FF, "reload");
  endtask

  // two clear lines, preset, clear priority, async load value
  task automatic t_async();
    apb(1'b1, LCRC_CFG_CTRL, 32'h0000_03E0);
    async_set(2'b01, 1'b0); `CHK(cell_reg, 10'h3E0, "clear line 0");
    async_set(2'b00, 1'b0); `CHK(cell_reg, 10'h3E0, "clear kept");
    async_set(2'b10, 1'b0); `CHK(cell_reg, 10'h000, "clear line 1");
    async_set(2'b00, 1'b1); `CHK(cell_reg, 10'h3FF, "preset");
    async_set(2'b11, 1'b1); `CHK(cell_reg, 10'h000, "clear wins");
    async_set(2'b00, 1'b0); `CHK(cell_reg, 10'h000, "clear stored");
    apb(1'b1, LCRC_CFG_CTRL, 32'h0001_0000);
    for (int i = 0; i < 10; i++) cell_data[i] <= (i % 2 == 0) ? 4'h8 : 4'h7;
    async_set(2'b00, 1'b1); `CHK(cell_reg, 10'h155, "aload input");
    async_set(2'b00, 1'b0);
  endtask

  // device reset beats everything, only when the build option is on
  task automatic t_devrst();
    cell_data <= '1;
    sync_pulse(1'b1, 1'b0, 1'b1);
    @(posedge sys_clk);
    device_wide_reset_n <= 1'b0;
    #1 `CHK(cell_reg, 10'h000, "dev reset at once");
    `CHK(nr_reg, 10'h3FF, "reset pin off");
    @(posedge sys_clk);
    grp_apre <= 1'b1; grp_ena <= 1'b1; grp_sload <= 1'b1;
    #1 `CHK(cell_reg, 10'h000, "dev reset over preset");
    @(posedge sys_clk);
    #1 `CHK(cell_reg, 10'h000, "dev reset over sload");
    `CHK(nr_reg, 10'h3FF, "pin off, load kept");
    @(posedge sys_clk);
    device_wide_reset_n <= 1'b1; grp_apre <= 1'b0;
    grp_ena <= 1'b0; grp_sload <= 1'b0;
    #1 `CHK(cell_reg, 10'h000, "dev reset stored");
  endtask

  // register chain shifts one cell per enabled edge
  task automatic t_rchain();
    cell_data <= '0;
    apb(1'b1, LCRC_CFG_CHAIN, 32'h0000_03FF);
    @(posedge sys_clk);
    grp_ena <= 1'b1; reg_chain_top <= 1'b1;
    @(posedge sys_clk);
    reg_chain_top <= 1'b0;
    repeat (2) @(posedge sys_clk);
    grp_ena <= 1'b0;
    #1 `CHK(cell_reg, 10'h004, "shift path");
    apb(1'b0, LCRC_STATUS, '0); `CHK(rd, 32'h0000_0004, "status");
  endtask

  // lut chain cascades through all ten cells, inverting each step
  task automatic t_lchain();
    for (int i = 0; i < 10; i++) apb(1'b1, 12'(4 * i), 32'h0000_5555);
    apb(1'b1, LCRC_CFG_CHAIN, 32'h03FF_0000);
    @(posedge sys_clk);
    lut_chain_top <= 1'b1;
    #1 `CHK(cell_comb, 10'h2AA, "cascade high");
    @(posedge sys_clk);
    lut_chain_top <= 1'b0;
    #1 `CHK(cell_comb, 10'h155, "cascade low");
  endtask

  // verdict and end of run
  task automatic conclude();
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs();
    t_sync();
    t_async();
    t_devrst();
    t_rchain();
    t_lchain();
    conclude();
  end

  // watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    #50000;
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
